/* design/timer_sync_pkg.sv */
package timer_sync_pkg;

	// ---------------------------------------------------------------
	// Register byte addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_SLAVE   = 8'h04;
	localparam logic [7:0] ADDR_CHAN    = 8'h08;
	localparam logic [7:0] ADDR_EVENT   = 8'h0C;
	localparam logic [7:0] ADDR_STATUS  = 8'h10;
	localparam logic [7:0] ADDR_COUNT   = 8'h14;
	localparam logic [7:0] ADDR_RELOAD  = 8'h18;
	localparam logic [7:0] ADDR_PRESC   = 8'h1C;
	localparam logic [7:0] ADDR_COMPARE = 8'h20;

	// ---------------------------------------------------------------
	// Control register fields
	// ---------------------------------------------------------------
	localparam int CTRL_CEN_BIT  = 0;
	localparam int CTRL_URS_BIT  = 2;
	localparam int CTRL_MMS_LSB  = 4;
	localparam int CTRL_IE_BIT   = 8;
	localparam int CTRL_DE_BIT   = 9;

	// ---------------------------------------------------------------
	// Slave register fields
	// ---------------------------------------------------------------
	localparam int SLV_SMS_LSB  = 0;
	localparam int SLV_TS_LSB   = 4;
	localparam int SLV_ETF_LSB  = 8;
	localparam int SLV_EXT_TRIGGER_PRESCALE_LSB = 12;
	localparam int SLV_ECE_BIT  = 14;
	localparam int SLV_ETP_BIT  = 15;

	// ---------------------------------------------------------------
	// Channel register fields (channel 1 low byte, channel 2 high)
	// ---------------------------------------------------------------
	localparam int CH_MAP_LSB  = 0;
	localparam int CH_POL_BIT  = 2;
	localparam int CH_FILT_LSB = 4;
	localparam int CH2_OFFSET  = 8;

	// ---------------------------------------------------------------
	// Event and status bits
	// ---------------------------------------------------------------
	localparam int EVT_UG_BIT   = 0;
	localparam int STAT_UIF_BIT = 0;
	localparam int STAT_TIF_BIT = 6;

	// ---------------------------------------------------------------
	// Encodings and reset values
	// ---------------------------------------------------------------
	localparam logic [2:0] SMS_OFF    = 3'h0;
	localparam logic [2:0] SMS_RESET  = 3'h4;
	localparam logic [2:0] SMS_GATED  = 3'h5;
	localparam logic [2:0] SMS_TRIG   = 3'h6;
	localparam logic [2:0] SMS_EXT1   = 3'h7;
	localparam logic [2:0] TS_INTERNAL_TRIGGER_ONE    = 3'h0;
	localparam logic [2:0] TS_TI1     = 3'h5;
	localparam logic [2:0] TS_TI2     = 3'h6;
	localparam logic [2:0] MMS_ENABLE = 3'h1;
	localparam logic [2:0] MMS_UPDATE = 3'h2;
	localparam logic [1:0] MAP_OWN    = 2'h1;
	localparam logic [15:0] RELOAD_RESET = 16'hFFFF;
	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// Timing counts
	// ---------------------------------------------------------------
	localparam int SYNC_STAGES = 2;

endpackage

/* design/timer_slave_master_sync.sv */
// Operation
// - reset mode trigger clears counter and prescaler
// - reset trigger makes update unless restricted
// - trigger sets flag, irq and dma
// - gated mode counts while trigger active
// - gated mode never counts without enable
// - gate open and close set flag
// - trigger mode edge starts counter, sets flag
// - trigger inputs resynchronised to timer clock
// - source select 000, 101, 110, 111
// - external clock 2 combines with slave modes
// - external trigger filter, prescaler, polarity
// - external clock 1 counts trigger rising edges
// - master mode 010 outputs update pulse
// - master mode 001 outputs counter enable
// - master mode 1xx outputs compare reference
// - gating only affects counter enable
// - update generate reinitialises counter, prescaler
// - untouched counter continues from current value
// - channel map 01, polarity selects edge
// - capture prescaler not in trigger path
// - trigger mode sets enable bit by hardware
`timescale 1ns/100ps
`default_nettype none

module timer_slave_master_sync
	import timer_sync_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// Trigger inputs
	input  wire logic        timer_input_one_i,
	input  wire logic        timer_input_two_i,
	input  wire logic        external_trigger_pin_i,
	input  wire logic        internal_trigger_one_i,
	// Master and request outputs
	output logic             master_trigger_out_o,
	output logic             trigger_irq_o,
	output logic             trigger_dma_o
);

	// ---------------------------------------------------------------
	// Types and registers
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_RESP = 2'b10
	} bus_state_t;

	bus_state_t  wr_state;
	logic [9:0]  ctrl;
	logic [15:0] slave_cfg;
	logic [15:0] chan_cfg;
	logic        trigger_flag;
	logic        update_flag;
	logic [15:0] count;
	logic [15:0] reload;
	logic [15:0] reload_shadow;
	logic [15:0] presc;
	logic [15:0] presc_shadow;
	logic [15:0] presc_cnt;
	logic [15:0] compare;
	logic [15:0] compare_shadow;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// Field views
	logic        counter_enable_bit;
	logic        update_source_restrict;
	logic [2:0]  master_mode_select;
	logic        trigger_irq_enable;
	logic        trigger_dma_enable;
	logic [2:0]  slave_mode_select;
	logic [2:0]  trigger_source_select;
	logic [3:0]  ext_trigger_filter;
	logic [1:0]  ext_trigger_prescale;
	logic        ext_clock2_enable;
	logic        ext_trigger_polarity;

	assign counter_enable_bit     = ctrl[CTRL_CEN_BIT];
	assign update_source_restrict = ctrl[CTRL_URS_BIT];
	assign master_mode_select     = ctrl[CTRL_MMS_LSB +: 3];
	assign trigger_irq_enable     = ctrl[CTRL_IE_BIT];
	assign trigger_dma_enable     = ctrl[CTRL_DE_BIT];
	assign slave_mode_select      = slave_cfg[SLV_SMS_LSB +: 3];
	assign trigger_source_select  = slave_cfg[SLV_TS_LSB +: 3];
	assign ext_trigger_filter     = slave_cfg[SLV_ETF_LSB +: 4];
	assign ext_trigger_prescale   = slave_cfg[SLV_EXT_TRIGGER_PRESCALE_LSB +: 2];
	assign ext_clock2_enable      = slave_cfg[SLV_ECE_BIT];
	assign ext_trigger_polarity   = slave_cfg[SLV_ETP_BIT];

	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------
	// Byte-lane merge of a write into a 16-bit field
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction

	// Filter length in samples; 0000 means none
	function automatic logic [3:0] filt_len(input logic [3:0] code);
		return (code == 4'h0) ? 4'h0 : code;
	endfunction

	// ---------------------------------------------------------------
	// Input resynchronisation
	// ---------------------------------------------------------------
	// two-stage synchronisers
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_a <= 4'h0;
			sync_b <= 4'h0;
		end else begin
			sync_a <= {internal_trigger_one_i, external_trigger_pin_i,
				timer_input_two_i, timer_input_one_i};
			sync_b <= sync_a;
		end
	end

	// ---------------------------------------------------------------
	// Digital filters: level must hold N+1 samples
	// ---------------------------------------------------------------
	// filter and polarity only, no capture prescaler
	logic [2:0] filt_out;
	logic [3:0] filt_cnt [3];
	logic [3:0] filt_code [3];
	assign filt_code[0] = chan_cfg[CH_FILT_LSB +: 4];
	assign filt_code[1] = chan_cfg[CH2_OFFSET + CH_FILT_LSB +: 4];
	assign filt_code[2] = ext_trigger_filter;

	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 3; i++) begin
			if (rst_i) begin
				filt_out[i] <= 1'b0;
				filt_cnt[i] <= 4'h0;
			end else if (sync_b[i] == filt_out[i]) begin
				filt_cnt[i] <= 4'h0;
			end else if (filt_cnt[i] >= filt_len(filt_code[i])) begin
				filt_out[i] <= sync_b[i];
				filt_cnt[i] <= 4'h0;
			end else begin
				filt_cnt[i] <= filt_cnt[i] + 4'h1;
			end
		end
	end

	// own-input map and polarity per channel
	logic ti1_fp;
	logic ti2_fp;
	assign ti1_fp = (chan_cfg[CH_MAP_LSB +: 2] == MAP_OWN)
		& (filt_out[0] ^ chan_cfg[CH_POL_BIT]);
	assign ti2_fp = (chan_cfg[CH2_OFFSET + CH_MAP_LSB +: 2] == MAP_OWN)
		& (filt_out[1] ^ chan_cfg[CH2_OFFSET + CH_POL_BIT]);

	// polarity then prescaler on the external pin
	logic       etr_pol;
	logic       etr_pol_d;
	logic [2:0] etr_div;
	logic       etr_clk_edge;
	assign etr_pol = filt_out[2] ^ ext_trigger_polarity;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			etr_pol_d    <= 1'b0;
			etr_div      <= 3'h0;
			etr_clk_edge <= 1'b0;
		end else begin
			etr_pol_d    <= etr_pol;
			etr_clk_edge <= 1'b0;
			if (etr_pol & ~etr_pol_d) begin
				etr_div <= etr_div + 3'h1;
				case (ext_trigger_prescale)
					2'h0: etr_clk_edge <= 1'b1;
					2'h1: etr_clk_edge <= etr_div[0];
					2'h2: etr_clk_edge <= &etr_div[1:0];
					default: etr_clk_edge <= &etr_div;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Trigger selection and edge detect
	// ---------------------------------------------------------------
	// trigger source select
	logic trig_level;
	always_comb begin
		case (trigger_source_select)
			TS_INTERNAL_TRIGGER_ONE: trig_level = sync_b[3];
			TS_TI1:  trig_level = ti1_fp;
			TS_TI2:  trig_level = ti2_fp;
			3'h7:    trig_level = etr_pol;
			default: trig_level = 1'b0;
		endcase
	end

	logic trig_d;
	logic trig_rise;
	logic trig_fall;
	assign trig_rise = trig_level & ~trig_d;
	assign trig_fall = ~trig_level & trig_d;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trig_d <= 1'b0;
		end else begin
			trig_d <= trig_level;
		end
	end

	// ---------------------------------------------------------------
	// Slave mode decisions
	// ---------------------------------------------------------------
	logic in_reset;
	logic in_gated;
	logic in_trig;
	logic in_ext1;
	logic trig_event;
	logic gated_on;
	logic cnt_en;
	logic tick_src;
	assign in_reset = (slave_mode_select == SMS_RESET);
	assign in_gated = (slave_mode_select == SMS_GATED);
	assign in_trig  = (slave_mode_select == SMS_TRIG);
	assign in_ext1  = (slave_mode_select == SMS_EXT1) & ~ext_clock2_enable;

	// gate open and close both flag
	assign gated_on = in_gated & (trig_rise | trig_fall);
	// one trigger event per active edge
	assign trig_event = ((in_reset | in_trig) & trig_rise) | gated_on;

	// gated counts only on active level
	// mode off means enable bit alone
	assign cnt_en = counter_enable_bit & (~in_gated | trig_level);

	// external clock 2 overrides tick source
	// external clock 1 counts trigger rises
	always_comb begin
		if (ext_clock2_enable) begin
			tick_src = etr_clk_edge;
		end else if (in_ext1) begin
			tick_src = trig_rise;
		end else begin
			tick_src = 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Counter, prescaler and preload
	// ---------------------------------------------------------------
	logic ug_req;
	logic cnt_wr;
	logic presc_wrap;
	logic overflow;
	logic update_event;
	logic reinit;
	assign presc_wrap = cnt_en & tick_src & (presc_cnt >= presc_shadow);
	assign overflow   = presc_wrap & (count >= reload_shadow);
	assign update_event = overflow | ug_req
		| (in_reset & trig_rise & ~update_source_restrict);
	// reset trigger clears; update generate too
	assign reinit = ug_req | (in_reset & trig_rise);

	// counter otherwise resumes from its value
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count     <= 16'h0;
			presc_cnt <= 16'h0;
		end else if (reinit) begin
			count     <= 16'h0;
			presc_cnt <= 16'h0;
		end else if (cnt_wr) begin
			count <= merge16(count, w_data, w_strb);
		end else if (cnt_en & tick_src) begin
			presc_cnt <= presc_wrap ? 16'h0 : presc_cnt + 16'h1;
			if (presc_wrap) begin
				count <= overflow ? 16'h0 : count + 16'h1;
			end
		end
	end

	// Shadow registers load on each update event
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reload_shadow  <= RELOAD_RESET;
			presc_shadow   <= 16'h0;
			compare_shadow <= 16'h0;
		end else if (update_event) begin
			reload_shadow  <= reload;
			presc_shadow   <= presc;
			compare_shadow <= compare;
		end
	end

	// ---------------------------------------------------------------
	// Master trigger output
	// ---------------------------------------------------------------
	// Simple PWM-style reference: high while count below compare
	logic ch1_compare_ref;
	assign ch1_compare_ref = (count < compare_shadow);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			master_trigger_out_o <= 1'b0;
		end else if (master_mode_select[2]) begin
			master_trigger_out_o <= ch1_compare_ref;
		end else if (master_mode_select == MMS_UPDATE) begin
			master_trigger_out_o <= update_event;
		end else if (master_mode_select == MMS_ENABLE) begin
			master_trigger_out_o <= cnt_en;
		end else begin
			master_trigger_out_o <= ug_req;
		end
	end

	// interrupt request follows flag; dma request pulses on each trigger event
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trigger_irq_o <= 1'b0;
			trigger_dma_o <= 1'b0;
		end else begin
			trigger_irq_o <= trigger_flag & trigger_irq_enable;
			trigger_dma_o <= trig_event & trigger_dma_enable;
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite write path
	// ---------------------------------------------------------------
	logic wr_go;
	assign wr_go = aw_held & w_held & (wr_state == BUS_IDLE);
	assign cnt_wr = wr_go & (aw_addr == ADDR_COUNT);
	assign ug_req = wr_go & (aw_addr == ADDR_EVENT) & w_strb[0]
		& w_data[EVT_UG_BIT];

	// Address and data are taken in either order
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aw_held         <= 1'b0;
			w_held          <= 1'b0;
			aw_addr         <= 8'h00;
			w_data          <= 32'h0;
			w_strb          <= 4'h0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
		end else begin
			if (s_axi_awvalid_i & s_axi_awready_o) begin
				aw_held         <= 1'b1;
				aw_addr         <= {s_axi_awaddr_i[7:2], 2'b00};
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i & s_axi_wready_o) begin
				w_held         <= 1'b1;
				w_data         <= s_axi_wdata_i;
				w_strb         <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (s_axi_bvalid_o & s_axi_bready_i) begin
				aw_held         <= 1'b0;
				w_held          <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	// Write response state machine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_state       <= BUS_IDLE;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= AXI_OKAY;
		end else begin
			case (wr_state)
				BUS_IDLE: begin
					if (wr_go) begin
						wr_state       <= BUS_RESP;
						s_axi_bvalid_o <= 1'b1;
						s_axi_bresp_o  <= (aw_addr > ADDR_COMPARE) ? AXI_SLVERR : AXI_OKAY;
					end
				end
				BUS_RESP: begin
					if (s_axi_bready_i) begin
						wr_state       <= BUS_IDLE;
						s_axi_bvalid_o <= 1'b0;
					end
				end
				default: wr_state <= BUS_IDLE;
			endcase
		end
	end

	// Configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl      <= 10'h0;
			slave_cfg <= 16'h0;
			chan_cfg  <= 16'h0;
			reload    <= RELOAD_RESET;
			presc     <= 16'h0;
			compare   <= 16'h0;
		end else begin
			if (wr_go) begin
				case (aw_addr)
					ADDR_CTRL:    ctrl      <= 10'(merge16({6'h0, ctrl}, w_data, w_strb));
					ADDR_SLAVE:   slave_cfg <= merge16(slave_cfg, w_data, w_strb);
					ADDR_CHAN:    chan_cfg  <= merge16(chan_cfg, w_data, w_strb);
					ADDR_RELOAD:  reload    <= merge16(reload, w_data, w_strb);
					ADDR_PRESC:   presc     <= merge16(presc, w_data, w_strb);
					ADDR_COMPARE: compare   <= merge16(compare, w_data, w_strb);
					default: ;
				endcase
			end
			if (in_trig & trig_rise) begin
				ctrl[CTRL_CEN_BIT] <= 1'b1;
			end
		end
	end

	// Status flags: hardware set wins over software clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trigger_flag <= 1'b0;
			update_flag  <= 1'b0;
		end else begin
			if (wr_go & (aw_addr == ADDR_STATUS) & w_strb[0]) begin
				if (!w_data[STAT_TIF_BIT]) trigger_flag <= 1'b0;
				if (!w_data[STAT_UIF_BIT]) update_flag <= 1'b0;
			end
			if (trig_event) trigger_flag <= 1'b1;
			if (update_event) update_flag <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite read path
	// ---------------------------------------------------------------
	logic [31:0] rd_mux;
	always_comb begin
		case ({s_axi_araddr_i[7:2], 2'b00})
			ADDR_CTRL:    rd_mux = {22'h0, ctrl};
			ADDR_SLAVE:   rd_mux = {16'h0, slave_cfg};
			ADDR_CHAN:    rd_mux = {16'h0, chan_cfg};
			ADDR_EVENT:   rd_mux = 32'h0;
			ADDR_STATUS:  rd_mux = {25'h0, trigger_flag, 5'h0, update_flag};
			ADDR_COUNT:   rd_mux = {16'h0, count};
			ADDR_RELOAD:  rd_mux = {16'h0, reload};
			ADDR_PRESC:   rd_mux = {16'h0, presc};
			ADDR_COMPARE: rd_mux = {16'h0, compare};
			default:      rd_mux = 32'h0;
		endcase
	end

	// Read takes one cycle; arready drops while data waits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0;
			s_axi_rresp_o   <= AXI_OKAY;
		end else if (s_axi_arvalid_i & s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rdata_o   <= rd_mux;
			s_axi_rresp_o   <= (s_axi_araddr_i > ADDR_COMPARE + 8'h3) ? AXI_SLVERR : AXI_OKAY;
		end else if (s_axi_rvalid_o & s_axi_rready_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
		end
	end

endmodule

`default_nettype wire

/* verif/timer_sync_sva.sv */
`timescale 1ns/100ps
`default_nettype none

module timer_sync_sva (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Bus handshakes
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	// Requests
	input wire logic        trigger_dma_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Answers stand until the master takes them
	a_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
		else $error("write response dropped early");
	a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> $stable(s_axi_bresp_o))
		else $error("write response code moved");
	a_rvalid_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
		else $error("read answer dropped early");
	a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> $stable(s_axi_rdata_o))
		else $error("read data moved");
	// One transfer at a time; dma request lasts one cycle
	a_write_refused: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write accepted while pending");
	a_read_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read accepted while pending");
	a_resp_clear: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
		else $error("write response repeated");
	a_dma_pulse: assert property ($rose(trigger_dma_o) |=> !trigger_dma_o)
		else $error("dma request longer than one cycle");
endmodule

bind timer_slave_master_sync timer_sync_sva u_sva (.clk_i, .rst_i, .s_axi_awready_o,
	.s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arready_o,
	.s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .trigger_dma_o);

`default_nettype wire

/* verif/trig_far_side.sv */
`timescale 1ns/100ps
`default_nettype none

module trig_far_side (
	// Clock
	input wire logic clk_i,
	// Trigger lines: 0 input one, 1 input two, 2 other timer, 3 pin
	output logic     ti1_o,
	output logic     ti2_o,
	output logic     itr_o,
	output logic     etr_o
);
	logic [3:0] lvl = 4'h0;

	// Lines are driven levels, never released
	assign {etr_o, itr_o, ti2_o, ti1_o} = lvl;

	// Level held long enough to pass the resynchroniser
	task automatic drive(input int k, input logic v);
		@(posedge clk_i);
		lvl[k] <= v;
		repeat (6) @(posedge clk_i);
	endtask

	// rise then fall: one rising and one falling edge per call
	task automatic pulse(input int k);
		drive(k, 1'b1);
		drive(k, 1'b0);
	endtask
endmodule

`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	import timer_sync_pkg::*;
	logic clk_i = 0, rst_i = 1;
	logic [7:0] aw = 0, ar = 0;
	logic [31:0] wd = 0, rd, rdata;
	logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, ti1, ti2, external_trigger_pin, itr, mto, irq, dma;
	logic [1:0] bresp, rresp, bs, rs, lanes = 2'b11;
	logic [3:0] ws = 4'hF;
	int n_errors = 0, num_checks = 0, n_dma = 0, n_mto = 0, model, r, ln;

	initial forever #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		n_dma <= n_dma + int'(dma === 1'b1);
		n_mto <= n_mto + int'(mto === 1'b1);
	end

	timer_slave_master_sync DUT (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(aw),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awready), .s_axi_wdata_i(wd),
		.s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .timer_input_one_i(ti1), .timer_input_two_i(ti2),
		.external_trigger_pin_i(external_trigger_pin), .internal_trigger_one_i(itr),
		.master_trigger_out_o(mto), .trigger_irq_o(irq), .trigger_dma_o(dma));
	trig_far_side u_far (.clk_i(clk_i), .ti1_o(ti1), .ti2_o(ti2), .itr_o(itr), .etr_o(external_trigger_pin));

	// ---------------------------------------------------------------
	// Bus master and compare
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Edge first, so a strobe is never set twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		aw <= a;
		wd <= d;
		ws <= {2'($urandom), lanes};
		awv <= 1;
		wv <= 1;
		bready <= 1'($urandom);
		forever begin
			@(posedge clk_i);
			if (awready) awv <= 0;
			if (wready) wv <= 0;
			if (bvalid && bready) break;
			if (bvalid) bready <= 1;
		end
		bs = bresp;
		bready <= 0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge clk_i);
		ar <= a;
		arv <= 1;
		rready <= 1'($urandom);
		forever begin
			@(posedge clk_i);
			if (arready) arv <= 0;
			if (rvalid && rready) break;
			if (rvalid) rready <= 1;
		end
		rd = rdata;
		rs = rresp;
		rready <= 0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		rdr(a);
		chk(rd, exp);
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Hang guard, far beyond the several hundred cycles needed
	initial begin
		#200000;
		n_errors++;
		tally_and_finish();
	end

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(32'h567C));
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		rdc(ADDR_RELOAD, {16'h0, RELOAD_RESET});
		rdc(ADDR_COUNT, 32'h0);
		rdc(8'h24, 32'h0);
		chk(rs, AXI_SLVERR);
		wr(8'h24, 32'h1);
		chk(bs, AXI_SLVERR);
		$display("test registers finished");
		wr(ADDR_CHAN, 32'h0101);
		for (int i = 0; i < 3; i++) begin
			ln = (i + 2) % 3;
			r = $urandom_range(32'hFFFF, 1);
			wr(ADDR_CTRL, 32'h300 | 32'(i == 2) << 2);
			wr(ADDR_SLAVE, 32'({(i == 0) ? TS_INTERNAL_TRIGGER_ONE : (i == 1) ? TS_TI1 : TS_TI2, 1'b0, SMS_RESET}));
			wr(ADDR_STATUS, 32'h0);
			wr(ADDR_COUNT, r);
			u_far.pulse((ln + 1) % 3);
			rdc(ADDR_COUNT, r);
			model = n_dma + 1;
			u_far.pulse(ln);
			rdc(ADDR_COUNT, 32'h0);
			rdc(ADDR_STATUS, (i == 2) ? 32'h40 : 32'h41);
			chk(irq, 1'b1);
			chk(n_dma, model);
		end
		$display("test reset mode finished");
		wr(ADDR_CHAN, 32'h0105);
		wr(ADDR_SLAVE, 32'({TS_TI1, 1'b0, SMS_RESET}));
		wr(ADDR_COUNT, r);
		u_far.drive(0, 1'b1);
		rdc(ADDR_COUNT, r);
		u_far.drive(0, 1'b0);
		rdc(ADDR_COUNT, 32'h0);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_SLAVE, 32'({TS_TI1, 1'b0, SMS_GATED}));
		wr(ADDR_COUNT, r);
		rdc(ADDR_COUNT, r);
		u_far.drive(0, 1'b1);
		wr(ADDR_STATUS, 32'h0);
		wr(ADDR_CTRL, 32'h1);
		rdc(ADDR_COUNT, r);
		u_far.drive(0, 1'b0);
		rdr(ADDR_COUNT);
		chk(rd !== r, 1'b1);
		rdr(ADDR_STATUS);
		chk(rd & 32'h40, 32'h40);
		wr(ADDR_STATUS, 32'h0);
		u_far.drive(0, 1'b1);
		rdr(ADDR_STATUS);
		chk(rd & 32'h40, 32'h40);
		rdr(ADDR_COUNT);
		rdc(ADDR_COUNT, rd);
		$display("test gated mode finished");
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_SLAVE, 32'({TS_TI2, 1'b0, SMS_TRIG}));
		wr(ADDR_STATUS, 32'h0);
		u_far.pulse(1);
		rdc(ADDR_CTRL, 32'h1);
		rdr(ADDR_STATUS);
		chk(rd & 32'h40, 32'h40);
		wr(ADDR_SLAVE, 32'h0);
		wr(ADDR_CTRL, 32'h11);
		repeat (3) @(posedge clk_i);
		chk(mto, 1'b1);
		rdr(ADDR_COUNT);
		model = rd;
		rdr(ADDR_COUNT);
		chk(rd !== model, 1'b1);
		wr(ADDR_CTRL, 32'h20);
		repeat (3) @(posedge clk_i);
		chk(mto, 1'b0);
		wr(ADDR_COUNT, r);
		model = n_mto + 1;
		wr(ADDR_EVENT, 32'h1);
		rdc(ADDR_COUNT, 32'h0);
		chk(n_mto, model);
		wr(ADDR_COMPARE, 32'h1234);
		lanes = 2'b01;
		wr(ADDR_COMPARE, 32'hABCD);
		lanes = 2'b11;
		rdc(ADDR_COMPARE, 32'h12CD);
		wr(ADDR_CTRL, 32'h40);
		wr(ADDR_EVENT, 32'h1);
		repeat (3) @(posedge clk_i);
		chk(mto, 1'b1);
		wr(ADDR_COUNT, 32'hFFFF);
		repeat (3) @(posedge clk_i);
		chk(mto, 1'b0);
		$display("test master out finished");
		u_far.drive(0, 1'b0);
		wr(ADDR_CHAN, 32'h0101);
		wr(ADDR_SLAVE, 32'({TS_TI1, 1'b0, SMS_EXT1}));
		wr(ADDR_CTRL, 32'h1);
		wr(ADDR_COUNT, 32'h0);
		repeat (5) u_far.pulse(0);
		rdc(ADDR_COUNT, 32'h5);
		for (int p = 0; p < 2; p++) begin
			wr(ADDR_SLAVE, 32'h4000 | p << 15);
			repeat (5) @(posedge clk_i);
			wr(ADDR_COUNT, 32'h0);
			repeat (5) u_far.pulse(3);
			rdc(ADDR_COUNT, 32'h5);
		end
		wr(ADDR_CTRL, 32'h0);
		// trigger taken from input one, not the pin
		wr(ADDR_SLAVE, 32'h4000 | 32'({TS_TI1, 1'b0, SMS_TRIG}));
		repeat (5) @(posedge clk_i);
		wr(ADDR_COUNT, 32'h0);
		u_far.pulse(3);
		rdc(ADDR_COUNT, 32'h0);
		u_far.pulse(0);
		repeat (3) u_far.pulse(3);
		rdc(ADDR_COUNT, 32'h3);
		$display("test external clock finished");
		tally_and_finish();
	end
endmodule

`default_nettype wire
